// ### logic/elcs_regs.vh
// Address map, field positions, reset values and timing for the emulated link register bank.
`ifndef ELCS_REGS_VH
`define ELCS_REGS_VH
`define ELCS_A_RP_LC2 8'h00
`define ELCS_A_EP_LC2 8'h04
`define ELCS_A_RP_LC3 8'h08
`define ELCS_A_EP_LC3 8'h0c
`define ELCS_A_LSTAT 8'h10
`define ELCS_A_S16 8'h14
`define ELCS_A_RP_MRG 8'h18
`define ELCS_A_EP_MRG 8'h1c
`define ELCS_A_MCAP 8'h20
`define ELCS_A_DLFC 8'h24
`define ELCS_A_DLFS 8'h28
`define ELCS_A_PAR_L 8'h2c
`define ELCS_A_PAR_R1 8'h30
`define ELCS_A_PAR_R2 8'h34
`define ELCS_A_LERR 8'h38
`define ELCS_A_ISTAT 8'h3c
`define ELCS_A_IMASK 8'h40
`define ELCS_A_LANE0 8'h80
`define ELCS_LC2_RST 16'h0004
`define ELCS_LC2_ECOMP 4
`define ELCS_LC3_PEQ 0
`define ELCS_LC3_MASK 32'h0000fe03
`define ELCS_SPD_16G 4'h4
`define ELCS_SUP_16G 3
`define ELCS_SUP_32G 4
`define ELCS_PRESET_MAX 4'ha
`define ELCS_MRG_TIME 3'h3
`define ELCS_MRG_HEALTHY 8'h80
`define ELCS_DLF_EN 31
`define ELCS_DLF_VALID 31
`define ELCS_CLK_NS 8
`define ELCS_EQ_HOLD_NS 2000
`define ELCS_IRQ_EQDONE 0
`define ELCS_IRQ_HOLD 1
`define ELCS_IRQ_PEQCLR 2
`define ELCS_IRQ_ACTIVE 3
`endif

// ### logic/elcs_link_regs.v
// Emulated link control, equalization, margining and error status registers for a port pair.
//
// Operation
// - Current speed is minimum of both targets
// - Endpoint speed write needs enter-compliance set
// - Root port compliance, de-emphasis, margin controls are stored only
// - Lower SKP vector, eq interrupt enable stored only
// - Lane equalization fields keep legal encodings
// - Time margining reports healthy results
// - Margining driver-software field reads zero
// - Sixteen GT equalization request never set
// - Eq bits set on qualified link-up request
// - Eq bits precede link-active by one cycle
// - Disable or hot reset fall holds eq bits
// - Retrain with perform-eq holds, then clears it
// - Hold visible, shorter than link-active delay
// - Both ports share one eq status
// - Per-lane sixteen GT presets stay in range
// - Data link feature registers act like real
// - Parity mismatch and lane error read zero
`timescale 1ns/10ps
`default_nettype none
`include "elcs_regs.vh"
module elcs_link_regs #(
   parameter LANES = 4,
   parameter [31:0] EQ_HOLD_CYC = `ELCS_EQ_HOLD_NS / `ELCS_CLK_NS,
   parameter [22:0] LOCAL_FEATURES = 23'h000001
) (
   // Clock and reset.
   input wire I_MCLK,
   input wire I_RST_N,
   // Register port.
   input wire [7:0] I_ADDR,
   input wire [31:0] I_WDATA,
   input wire I_WR,
   input wire I_RD,
   output reg [31:0] O_RDATA,
   // Link emulation controls.
   input wire [6:0] I_SUP_SPEEDS,
   input wire I_EQ32_BYPASS_DIS,
   input wire I_LINK_UP_REQ,
   input wire I_LINK_DISABLE,
   input wire I_HOT_RESET,
   input wire I_RETRAIN,
   input wire [22:0] I_EP_FEATURES,
   // Link state.
   output reg O_LINK_ACTIVE,
   output reg [3:0] O_CUR_SPEED,
   // Interrupt.
   output reg O_IRQ
);
   localparam ST_DOWN = 2'h0;
   localparam ST_EQ = 2'h1;
   localparam ST_UP = 2'h2;

   reg [15:0] rp_lc2_q, ep_lc2_q;
   reg [31:0] rp_lc3_q, ep_lc3_q;
   reg [15:0] rp_mctl_q, ep_mctl_q;
   reg [15:0] rp_msts_q, ep_msts_q;
   reg [3:0] eq16_q;
   reg [31:0] dlfc_q;
   reg [31:0] dlfs_q;
   reg [3:0] isr_q, imask_q;
   reg [1:0] st_q;
   reg [31:0] hold_cnt_q;
   reg hold_retrain_q;
   reg dis_q, hrst_q;
   reg [15:0] leq8_q [0:LANES-1];
   reg [7:0] leq16_q [0:LANES-1];
   wire wr_hit;
   wire eq_ok;
   wire hold_start;
   wire retrain_eq;
   wire hold_end;
   wire [3:0] min_spd;
   reg [3:0] ev;
   reg [31:0] rd_d;
   integer k;

   // Both ports see the slower of the two targets, as a real link trains to the common rate.
   assign min_spd = (rp_lc2_q[3:0] < ep_lc2_q[3:0]) ? rp_lc2_q[3:0] : ep_lc2_q[3:0];

   assign eq_ok = I_SUP_SPEEDS[`ELCS_SUP_16G] &
                  (~I_SUP_SPEEDS[`ELCS_SUP_32G] | I_EQ32_BYPASS_DIS);
   assign retrain_eq = I_RETRAIN & (rp_lc2_q[3:0] >= `ELCS_SPD_16G) &
                       rp_lc3_q[`ELCS_LC3_PEQ];
   assign hold_start = (dis_q & ~I_LINK_DISABLE) | (hrst_q & ~I_HOT_RESET) | retrain_eq;
   assign hold_end = (hold_cnt_q == 32'h00000001);

   // Link sequencing and equalization status, shared by both ports.
   always @(posedge I_MCLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         st_q <= ST_DOWN;
         eq16_q <= 4'h0;
         hold_cnt_q <= 32'h00000000;
         hold_retrain_q <= 1'b0;
         dis_q <= 1'b0;
         hrst_q <= 1'b0;
         O_LINK_ACTIVE <= 1'b0;
         O_CUR_SPEED <= 4'h0;
         dlfs_q <= 32'h00000000;
      end else begin
         dis_q <= I_LINK_DISABLE;
         hrst_q <= I_HOT_RESET;
         O_CUR_SPEED <= min_spd;
         if (hold_start) begin
            // The hold is a fixed count well below the link-up delay of the partner logic.
            hold_cnt_q <= EQ_HOLD_CYC;
            hold_retrain_q <= retrain_eq;
            eq16_q <= 4'h0;
         end else if (hold_cnt_q != 32'h00000000) begin
            hold_cnt_q <= hold_cnt_q - 32'h00000001;
            eq16_q <= 4'h0;
            if (hold_end && hold_retrain_q && st_q == ST_UP && eq_ok) begin
               eq16_q <= 4'hf;
            end
         end
         case (st_q)
            ST_DOWN: begin
               // Link-active is withheld during a hold so software can poll the zeros.
               if (I_LINK_UP_REQ && hold_cnt_q == 32'h00000000 && !hold_start) begin
                  st_q <= ST_EQ;
                  if (eq_ok) begin
                     eq16_q <= 4'hf;
                  end
               end
            end
            ST_EQ: begin
               if (I_LINK_UP_REQ) begin
                  st_q <= ST_UP;
                  O_LINK_ACTIVE <= 1'b1;
                  dlfs_q[`ELCS_DLF_VALID] <= dlfc_q[`ELCS_DLF_EN];
                  dlfs_q[22:0] <= dlfc_q[`ELCS_DLF_EN] ? I_EP_FEATURES : 23'h000000;
               end else begin
                  st_q <= ST_DOWN;
               end
            end
            ST_UP: begin
               if (!I_LINK_UP_REQ) begin
                  st_q <= ST_DOWN;
                  O_LINK_ACTIVE <= 1'b0;
                  dlfs_q <= 32'h00000000;
               end
            end
            default: begin
               st_q <= ST_DOWN;
               O_LINK_ACTIVE <= 1'b0;
            end
         endcase
      end
   end

   assign wr_hit = I_WR;

   // Control registers; ignored controls are stored and read back unchanged.
   always @(posedge I_MCLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         rp_lc2_q <= `ELCS_LC2_RST;
         ep_lc2_q <= `ELCS_LC2_RST;
         rp_lc3_q <= 32'h00000000;
         ep_lc3_q <= 32'h00000000;
         dlfc_q <= 32'h00000000;
         imask_q <= 4'h0;
      end else begin
         if (wr_hit) begin
            case (I_ADDR)
               `ELCS_A_RP_LC2: begin
                  // Enter-compliance is stored but steers nothing here.
                  rp_lc2_q <= I_WDATA[15:0];
               end
               `ELCS_A_EP_LC2: begin
                  ep_lc2_q[15:4] <= I_WDATA[15:4];
                  if (ep_lc2_q[`ELCS_LC2_ECOMP] | I_WDATA[`ELCS_LC2_ECOMP]) begin
                     ep_lc2_q[3:0] <= I_WDATA[3:0];
                  end
               end
               `ELCS_A_RP_LC3: rp_lc3_q <= I_WDATA & `ELCS_LC3_MASK;
               `ELCS_A_EP_LC3: ep_lc3_q <= I_WDATA & `ELCS_LC3_MASK;
               `ELCS_A_DLFC: dlfc_q[`ELCS_DLF_EN] <= I_WDATA[`ELCS_DLF_EN];
               `ELCS_A_IMASK: imask_q <= I_WDATA[3:0];
               default: begin
               end
            endcase
         end
         dlfc_q[22:0] <= LOCAL_FEATURES;
         if (hold_end && hold_retrain_q) begin
            // Cleared only once the zero window has been shown.
            rp_lc3_q[`ELCS_LC3_PEQ] <= 1'b0;
            ep_lc3_q[`ELCS_LC3_PEQ] <= 1'b0;
         end
      end
   end

   // Margining: only time margining is emulated and it always passes with no errors.
   always @(posedge I_MCLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         rp_mctl_q <= 16'h0000;
         ep_mctl_q <= 16'h0000;
         rp_msts_q <= 16'h0000;
         ep_msts_q <= 16'h0000;
      end else if (wr_hit && I_ADDR == `ELCS_A_RP_MRG) begin
         rp_mctl_q <= I_WDATA[15:0];
         rp_msts_q[7:0] <= I_WDATA[7:0];
         rp_msts_q[15:8] <= (I_WDATA[5:3] == `ELCS_MRG_TIME) ?
                            `ELCS_MRG_HEALTHY : I_WDATA[15:8];
      end else if (wr_hit && I_ADDR == `ELCS_A_EP_MRG) begin
         ep_mctl_q <= I_WDATA[15:0];
         ep_msts_q[7:0] <= I_WDATA[7:0];
         ep_msts_q[15:8] <= (I_WDATA[5:3] == `ELCS_MRG_TIME) ?
                            `ELCS_MRG_HEALTHY : I_WDATA[15:8];
      end
   end

   // Per-lane equalization presets; a reserved preset code leaves the field as it was.
   genvar g;
   generate
      for (g = 0; g < LANES; g = g + 1) begin : g_lane
         always @(posedge I_MCLK or negedge I_RST_N) begin
            if (!I_RST_N) begin
               leq8_q[g] <= 16'h0000;
               leq16_q[g] <= 8'h00;
            end else if (wr_hit && I_ADDR == `ELCS_A_LANE0 + g * 4) begin
               if (I_WDATA[3:0] <= `ELCS_PRESET_MAX) begin
                  leq8_q[g][3:0] <= I_WDATA[3:0];
               end
               if (I_WDATA[6:4] != 3'h7) begin
                  leq8_q[g][6:4] <= I_WDATA[6:4];
               end
               if (I_WDATA[11:8] <= `ELCS_PRESET_MAX) begin
                  leq8_q[g][11:8] <= I_WDATA[11:8];
               end
               if (I_WDATA[14:12] != 3'h7) begin
                  leq8_q[g][14:12] <= I_WDATA[14:12];
               end
               if (I_WDATA[19:16] <= `ELCS_PRESET_MAX) begin
                  leq16_q[g][3:0] <= I_WDATA[19:16];
               end
               if (I_WDATA[23:20] <= `ELCS_PRESET_MAX) begin
                  leq16_q[g][7:4] <= I_WDATA[23:20];
               end
            end
         end
      end
   endgenerate

   // Interrupt sources are edges of the block's own sequencing.
   always @* begin
      ev = 4'h0;
      ev[`ELCS_IRQ_EQDONE] = (st_q == ST_DOWN) && I_LINK_UP_REQ && (hold_cnt_q == 32'h00000000)
                             && !hold_start && eq_ok;
      ev[`ELCS_IRQ_HOLD] = hold_start;
      ev[`ELCS_IRQ_PEQCLR] = hold_end && hold_retrain_q;
      ev[`ELCS_IRQ_ACTIVE] = (st_q == ST_EQ) && I_LINK_UP_REQ;
   end

   // A new event in the clearing cycle survives the write-one-to-clear.
   always @(posedge I_MCLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         isr_q <= 4'h0;
         O_IRQ <= 1'b0;
      end else begin
         if (wr_hit && I_ADDR == `ELCS_A_ISTAT) begin
            isr_q <= (isr_q & ~I_WDATA[3:0]) | ev;
         end else begin
            isr_q <= isr_q | ev;
         end
         O_IRQ <= |(isr_q & imask_q);
      end
   end

   // Read mux; unmapped offsets and the error status registers read as zero.
   always @* begin
      rd_d = 32'h00000000;
      case (I_ADDR)
         `ELCS_A_RP_LC2: rd_d = {16'h0000, rp_lc2_q};
         `ELCS_A_EP_LC2: rd_d = {16'h0000, ep_lc2_q};
         `ELCS_A_RP_LC3: rd_d = rp_lc3_q;
         `ELCS_A_EP_LC3: rd_d = ep_lc3_q;
         `ELCS_A_LSTAT: rd_d = {27'h0000000, O_LINK_ACTIVE, O_CUR_SPEED};
         `ELCS_A_S16: rd_d = {27'h0000000, 1'b0, eq16_q};
         `ELCS_A_RP_MRG: rd_d = {rp_msts_q, rp_mctl_q};
         `ELCS_A_EP_MRG: rd_d = {ep_msts_q, ep_mctl_q};
         `ELCS_A_MCAP: rd_d = 32'h00000000;
         `ELCS_A_DLFC: rd_d = dlfc_q;
         `ELCS_A_DLFS: rd_d = dlfs_q;
         `ELCS_A_PAR_L: rd_d = 32'h00000000;
         `ELCS_A_PAR_R1: rd_d = 32'h00000000;
         `ELCS_A_PAR_R2: rd_d = 32'h00000000;
         `ELCS_A_LERR: rd_d = 32'h00000000;
         `ELCS_A_ISTAT: rd_d = {28'h0000000, isr_q};
         `ELCS_A_IMASK: rd_d = {28'h0000000, imask_q};
         default: begin
            for (k = 0; k < LANES; k = k + 1) begin
               if (I_ADDR == `ELCS_A_LANE0 + k * 4) begin
                  rd_d = {8'h00, leq16_q[k], leq8_q[k]};
               end
            end
         end
      endcase
   end

   always @(posedge I_MCLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         O_RDATA <= 32'h00000000;
      end else if (I_RD) begin
         O_RDATA <= rd_d;
      end else begin
         O_RDATA <= 32'h00000000;
      end
   end
endmodule
`default_nettype wire

// ### verification/elcs_link_properties.sv
// Port-level assertions for the emulated link register bank.
`timescale 1ns/10ps
`default_nettype none
module elcs_link_properties #(
   parameter [31:0] EQ_HOLD_CYC = 8
) (
   input wire I_MCLK,
   input wire I_RST_N,
   input wire [7:0] I_ADDR,
   input wire I_WR,
   input wire I_RD,
   input wire [31:0] O_RDATA,
   input wire I_LINK_UP_REQ,
   input wire I_LINK_DISABLE,
   input wire I_HOT_RESET,
   input wire O_LINK_ACTIVE,
   input wire [3:0] O_CUR_SPEED
);
   default clocking @(posedge I_MCLK); endclocking
   default disable iff (!I_RST_N);
   property p_zero_regs;
      $past(I_RD) && ($past(I_ADDR) inside {8'h2c, 8'h30, 8'h34, 8'h38}) |-> O_RDATA == 32'h0;
   endproperty
   a_zero_regs: assert property (p_zero_regs)
      else $error("error status register not zero");
   property p_mcap;
      $past(I_RD) && $past(I_ADDR) == 8'h20 |-> O_RDATA == 32'h0;
   endproperty
   a_mcap: assert property (p_mcap)
      else $error("margining capabilities not zero");
   property p_eq_req;
      $past(I_RD) && $past(I_ADDR) == 8'h14 |-> !O_RDATA[4];
   endproperty
   a_eq_req: assert property (p_eq_req)
      else $error("equalization request bit set");
   property p_lane;
      $past(I_RD) && $past(I_ADDR) >= 8'h80 && $past(I_ADDR) <= 8'h8c
         |-> O_RDATA[3:0] <= 4'ha && O_RDATA[11:8] <= 4'ha
            && O_RDATA[19:16] <= 4'ha && O_RDATA[23:20] <= 4'ha;
   endproperty
   a_lane: assert property (p_lane)
      else $error("lane preset out of range");
   property p_speed;
      $changed(O_CUR_SPEED) && $past(I_RST_N, 3)
         |-> $past(I_WR, 2) && ($past(I_ADDR, 2) == 8'h00 || $past(I_ADDR, 2) == 8'h04);
   endproperty
   a_speed: assert property (p_speed)
      else $error("current speed moved without a target write");
   property p_rise;
      $rose(O_LINK_ACTIVE) |-> $past(I_LINK_UP_REQ) && $past(I_LINK_UP_REQ, 2);
   endproperty
   a_rise: assert property (p_rise)
      else $error("link active rose without equalization cycle");
   property p_drop;
      O_LINK_ACTIVE && !I_LINK_UP_REQ |=> !O_LINK_ACTIVE;
   endproperty
   a_drop: assert property (p_drop)
      else $error("link active stayed after request dropped");
   property p_hold;
      EQ_HOLD_CYC >= 8 && ($fell(I_LINK_DISABLE) || $fell(I_HOT_RESET)) && !O_LINK_ACTIVE
         |=> !O_LINK_ACTIVE [*8];
   endproperty
   a_hold: assert property (p_hold)
      else $error("link came up inside equalization hold");
endmodule
bind elcs_link_regs elcs_link_properties #(.EQ_HOLD_CYC(EQ_HOLD_CYC)) u_props (
   .I_MCLK(I_MCLK), .I_RST_N(I_RST_N), .I_ADDR(I_ADDR), .I_WR(I_WR), .I_RD(I_RD),
   .O_RDATA(O_RDATA), .I_LINK_UP_REQ(I_LINK_UP_REQ), .I_LINK_DISABLE(I_LINK_DISABLE),
   .I_HOT_RESET(I_HOT_RESET), .O_LINK_ACTIVE(O_LINK_ACTIVE), .O_CUR_SPEED(O_CUR_SPEED));
`default_nettype wire

// ### verification/elcs_partner.sv
// Paired port logic that requests link up after a training delay.
`timescale 1ns/10ps
`default_nettype none
module elcs_partner #(
   parameter int DLY = 24
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_want,
   input wire logic i_disable,
   input wire logic i_hot_reset,
   output logic o_up_req
);
   int cnt;
   // Training takes longer than the equalization hold, so polling sees the hold.
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n || !i_want || i_disable || i_hot_reset) begin
         cnt <= 0;
         o_up_req <= 1'b0;
      end else if (cnt < DLY) begin
         cnt <= cnt + 1;
      end else begin
         o_up_req <= 1'b1;
      end
   end
endmodule
`default_nettype wire

// ### verification/test_emulated_link_ctrl_status_regs.sv
// Self-checking bench for the emulated link register bank.
`timescale 1ns/10ps
`default_nettype none
module test_emulated_link_ctrl_status_regs;
   logic mclk, rst_n, wr, rd, byp, dis, hrst, retr, want, up, act, irq;
   logic [7:0] addr;
   logic [31:0] wdata, rdata, r;
   logic [6:0] sup;
   logic [22:0] feat;
   logic [3:0] spd;
   logic [31:0] seed = 32'd45194;
   logic [7:0] zr [6] = '{8'h20, 8'h2c, 8'h30, 8'h34, 8'h38, 8'h50};
   int fails = 0, check_count = 0, rp, ep, e, i;
   elcs_link_regs #(.EQ_HOLD_CYC(8)) dut (.I_MCLK(mclk), .I_RST_N(rst_n), .I_ADDR(addr),
      .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_SUP_SPEEDS(sup),
      .I_EQ32_BYPASS_DIS(byp), .I_LINK_UP_REQ(up), .I_LINK_DISABLE(dis), .I_HOT_RESET(hrst),
      .I_RETRAIN(retr), .I_EP_FEATURES(feat), .O_LINK_ACTIVE(act), .O_CUR_SPEED(spd),
      .O_IRQ(irq));
   elcs_partner u_far (.i_clk(mclk), .i_rst_n(rst_n), .i_want(want), .i_disable(dis),
      .i_hot_reset(hrst), .o_up_req(up));
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic complete_run();
      $display("checks %0d fails %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Each access spends two cycles so a strobe is never lowered and raised in one step.
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] m,
                         input logic [31:0] exp);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      @(negedge mclk);
      chk(nm, rdata & m, exp);
      @(posedge mclk);
   endtask
   task automatic wait_act(input logic v);
      int n;
      for (n = 0; n < 200 && act !== v; n++) @(posedge mclk);
      if (act !== v) begin
         fails++;
         complete_run();
      end
   endtask
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   initial begin
      {addr, wdata, wr, rd, byp, dis, hrst, retr, want, rst_n} = '0;
      sup = 7'h0f;
      feat = 23'(rnd());
      rp = 4;
      ep = 4;
      repeat (4) @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk);
      rd_chk("rp_lc2", 8'h00, 32'hffff, 32'h4);
      rd_chk("lstat", 8'h10, 32'h1f, 32'h4);
      for (i = 0; i < 8; i++) begin
         r = rnd();
         rp = (r & 'hfff0) | (r % 4 + 1);
         e = ((r >> 16) & 'hffe0) | (r & 'h10) | ((r >> 22) % 4 + 1);
         ep = ((ep | e) & 'h10) ? e : ((e & 'hfff0) | (ep & 15));
         wr_reg(8'h00, rp);
         wr_reg(8'h04, e);
         rd_chk("rp_lc2", 8'h00, 32'hffff, rp);
         rd_chk("ep_lc2", 8'h04, 32'hffff, ep);
         // Speed is looked at well after its last update, never in the step that launches it.
         chk("cur_speed", spd, ((rp & 15) < (ep & 15)) ? rp & 15 : ep & 15);
      end
      $display("speed test done");
      wr_reg(8'h0c, 32'hffffffff);
      rd_chk("ep_lc3", 8'h0c, 32'hffffffff, 32'hfe03);
      foreach (zr[i]) rd_chk("zero", zr[i], 32'hffffffff, 32'h0);
      for (i = 0; i < 2; i++) begin
         wr_reg(8'h18 + 8'(4 * i), 32'h19);
         rd_chk("margin", 8'h18 + 8'(4 * i), 32'hffffffff, 32'h80190019);
      end
      for (i = 0; i < 4; i++) begin
         wr_reg(8'h80 + 8'(4 * i), 32'h00553535);
         wr_reg(8'h80 + 8'(4 * i), 32'h00bb7b7b);
         rd_chk("lane", 8'h80 + 8'(4 * i), 32'h00ff7f7f, 32'h00553535);
      end
      $display("register test done");
      wr_reg(8'h24, 32'h80000000);
      want <= 1'b1;
      wait_act(1'b1);
      rd_chk("s16", 8'h14, 32'hffffffff, 32'hf);
      rd_chk("dlf_stat", 8'h28, 32'hffffffff, {9'h100, feat});
      // Passes 2 and 3 offer 32 GT/s, first without and then with the bypass disable.
      for (i = 0; i < 4; i++) begin
         sup <= (i > 1) ? 7'h1f : 7'h0f;
         byp <= (i == 3);
         {hrst, dis} <= i[0] ? 2'b10 : 2'b01;
         wait_act(1'b0);
         {hrst, dis} <= 2'b00;
         @(posedge mclk);
         rd_chk("s16_hold", 8'h14, 32'hf, 32'h0);
         wait_act(1'b1);
         rd_chk("s16_up", 8'h14, 32'hf, (i == 2) ? 32'h0 : 32'hf);
      end
      wr_reg(8'h00, 32'h4);
      wr_reg(8'h08, 32'h1);
      retr <= 1'b1;
      @(posedge mclk);
      retr <= 1'b0;
      rd_chk("s16_rt", 8'h14, 32'hf, 32'h0);
      repeat (12) @(posedge mclk);
      rd_chk("peq", 8'h08, 32'h1, 32'h0);
      rd_chk("s16_rt2", 8'h14, 32'hf, 32'hf);
      $display("link test done");
      rd_chk("irq_stat", 8'h3c, 32'hf, 32'hf);
      // The interrupt output follows status and mask one edge late, so wait one more edge.
      wr_reg(8'h40, 32'hf);
      @(posedge mclk);
      chk("irq_on", irq, 1'b1);
      wr_reg(8'h40, 32'h0);
      @(posedge mclk);
      chk("irq_mask", irq, 1'b0);
      wr_reg(8'h40, 32'hf);
      wr_reg(8'h3c, 32'hf);
      @(posedge mclk);
      chk("irq_clr", irq, 1'b0);
      want <= 1'b0;
      wait_act(1'b0);
      $display("interrupt test done");
      complete_run();
   end
endmodule
`default_nettype wire
